// >>> rtl/sacc_cfg.svh
// Register offsets, field positions, reset values and conversion counts
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH

// ----------------------------------------
// Register byte offsets on the APB
// ----------------------------------------
`define SACC_OFF_CTRL_A 12'h000
`define SACC_OFF_CTRL_B 12'h004
`define SACC_OFF_INSEL 12'h008
`define SACC_OFF_RES_LO 12'h00c
`define SACC_OFF_RES_HI 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SACC_A_ON 7
`define SACC_A_GO 6
`define SACC_A_AUTO 5
`define SACC_A_FLAG 4
`define SACC_S_LEFT 5
`define SACC_S_REF_HI 7
`define SACC_S_REF_LO 6
`define SACC_S_CHAN_HI 4
`define SACC_B_TRIG_HI 2

// ----------------------------------------
// Reset values and conversion timing
// ----------------------------------------
`define SACC_RST_BYTE 8'h00
`define SACC_LEN_NORMAL 5'd13
`define SACC_LEN_FIRST 5'd25
`define SACC_RES_BITS 5'd10
`define SACC_TRIG_FREE 3'h0
`define SACC_SAR_MSB 10'h200
`define SACC_SAR_LSB 10'h001

`endif

// >>> rtl/sacc_edge_det.sv
// Rising edge detector for the selected trigger level
`timescale 1ns/1ps
module sacc_edge_det (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic level,
   output logic rise
);
   sacc_pkg::sacc_edge_type s_q;
   sacc_pkg::sacc_edge_type s_d;

   always_comb begin
      s_d = s_q;
      s_d.prev = level;
   end

   // A level held high gives no second edge
   assign rise = level && !s_q.prev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
endmodule

// >>> rtl/sacc_pkg.sv
// Types shared by the converter control block
package sacc_pkg;

   typedef enum logic [1:0] {SACC_IDLE, SACC_ARMED, SACC_CONVERT} sacc_phase_type;

   typedef struct packed {
      logic on;
      logic go;
      logic auto;
      logic flag;
      logic [2:0] trigSel;
      logic [1:0] refSel;
      logic left;
      logic [4:0] chanSel;
      logic [1:0] feRef;
      logic [4:0] feChan;
      logic feEn;
      logic [9:0] dac;
      logic [9:0] result;
      logic lock;
      logic warm;
      logic [4:0] cnt;
      sacc_phase_type st;
      logic presClr;
      logic [7:0] rdByte;
      logic pready;
      logic pslverr;
   } sacc_regs_type;

   typedef struct packed {
      logic [7:0] count;
   } sacc_pres_type;

   typedef struct packed {
      logic prev;
   } sacc_edge_type;

endpackage

// >>> rtl/sacc_prescaler.sv
// Converter clock prescaler: one tick per DIV system clocks
`timescale 1ns/1ps
module sacc_prescaler #(
   parameter logic [7:0] DIV = 8'd2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clear,
   output logic tick
);
   sacc_pkg::sacc_pres_type s_q;
   sacc_pkg::sacc_pres_type s_d;

   // Clear holds the count at zero, so the first tick after release is DIV clocks later
   always_comb begin
      s_d = s_q;
      if (clear || s_q.count == DIV - 8'd1) begin
         s_d.count = 8'h00;
      end else begin
         s_d.count = s_q.count + 8'h01;
      end
   end

   assign tick = !clear && s_q.count == DIV - 8'd1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
endmodule

// >>> rtl/sacc_top.sv
// Successive-approximation converter control with APB register access
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "sacc_cfg.svh"
module sacc_top #(
   parameter logic [7:0] PRESCALE = 8'd2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] trigEvents,
   input wire logic feCompare,
   output logic feEnable,
   output logic [4:0] feChannel,
   output logic [1:0] feReference,
   output logic [9:0] feDacCode,
   output logic convDoneFlag
);
   sacc_pkg::sacc_regs_type s_q;
   sacc_pkg::sacc_regs_type s_d;
   logic tick;
   logic trigLevel;
   logic trigRise;
   logic setup;
   logic wrEn;
   logic freeRun;
   logic complete;
   logic inBits;
   logic [4:0] convLen;
   logic [3:0] bitIdx;
   logic [9:0] bitMask;
   logic [9:0] nextDac;

   // ----------------------------------------
   // Prescaler and trigger edge
   // ----------------------------------------
   sacc_prescaler #(
      .DIV(PRESCALE)
   ) u_pres (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clear(!s_q.on || s_q.presClr),
      .tick(tick)
   );

   // Done flag as source starts nothing: free running restarts on completion, and the edge start excludes it
   assign trigLevel = (s_q.trigSel == `SACC_TRIG_FREE) ? s_q.flag
                      : trigEvents[s_q.trigSel];

   sacc_edge_det u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .level(trigLevel),
      .rise(trigRise)
   );

   // ----------------------------------------
   // Conversion helpers
   // ----------------------------------------
   assign setup = psel && !penable;
   assign wrEn = psel && penable && pwrite && s_q.pready;
   assign freeRun = s_q.auto && s_q.trigSel == `SACC_TRIG_FREE;
   assign convLen = s_q.warm ? `SACC_LEN_NORMAL : `SACC_LEN_FIRST;
   assign inBits = s_q.cnt >= convLen - `SACC_RES_BITS;
   assign bitIdx = 4'(convLen - 5'd1 - s_q.cnt);
   assign bitMask = `SACC_SAR_LSB << bitIdx;
   // Comparator high means input above trial, so the trial bit stays
   assign nextDac = (s_q.dac & ~bitMask) | (feCompare ? bitMask : 10'h000)
                    | (bitMask >> 1);
   assign complete = s_q.st == sacc_pkg::SACC_CONVERT && tick
                     && s_q.cnt == convLen - 5'd1;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.presClr = 1'b0;
      s_d.pready = setup;
      s_d.pslverr = 1'b0;
      // Read data and read side effects are taken in the setup cycle, so a
      // completion racing the access cannot split a low/high pair
      if (setup) begin
         s_d.rdByte = `SACC_RST_BYTE;
         if (!pwrite) begin
            case (paddr)
               `SACC_OFF_CTRL_A: begin
                  s_d.rdByte = {s_q.on, s_q.go, s_q.auto, s_q.flag, 4'h0};
               end
               `SACC_OFF_CTRL_B: begin
                  s_d.rdByte = {5'h00, s_q.trigSel};
               end
               `SACC_OFF_INSEL: begin
                  s_d.rdByte = {s_q.refSel, s_q.left, s_q.chanSel};
               end
               `SACC_OFF_RES_LO: begin
                  s_d.rdByte = s_q.left ? {s_q.result[1:0], 6'h00}
                               : s_q.result[7:0];
                  s_d.lock = 1'b1;
               end
               `SACC_OFF_RES_HI: begin
                  s_d.rdByte = s_q.left ? s_q.result[9:2]
                               : {6'h00, s_q.result[9:8]};
                  s_d.lock = 1'b0;
               end
               default: begin
                  s_d.pslverr = 1'b1;
               end
            endcase
         end else begin
            case (paddr)
               `SACC_OFF_CTRL_A, `SACC_OFF_CTRL_B, `SACC_OFF_INSEL,
               `SACC_OFF_RES_LO, `SACC_OFF_RES_HI: begin
                  s_d.pslverr = 1'b0;
               end
               default: begin
                  s_d.pslverr = 1'b1;
               end
            endcase
         end
      end
      if (wrEn) begin
         case (paddr)
            `SACC_OFF_CTRL_A: begin
               s_d.on = pwdata[`SACC_A_ON];
               s_d.auto = pwdata[`SACC_A_AUTO];
               if (pwdata[`SACC_A_FLAG]) begin
                  s_d.flag = 1'b0;
               end
            end
            `SACC_OFF_CTRL_B: begin
               s_d.trigSel = pwdata[`SACC_B_TRIG_HI:0];
            end
            `SACC_OFF_INSEL: begin
               s_d.refSel = pwdata[`SACC_S_REF_HI:`SACC_S_REF_LO];
               s_d.left = pwdata[`SACC_S_LEFT];
               s_d.chanSel = pwdata[`SACC_S_CHAN_HI:0];
            end
            default: begin
               s_d.on = s_q.on;
            end
         endcase
      end
      // Selection follows software only outside a conversion
      if (s_d.on && s_q.st != sacc_pkg::SACC_CONVERT) begin
         s_d.feChan = s_d.chanSel;
         s_d.feRef = s_d.refSel;
      end
      s_d.feEn = s_d.on;
      case (s_q.st)
         sacc_pkg::SACC_IDLE: begin
            if (wrEn && paddr == `SACC_OFF_CTRL_A && pwdata[`SACC_A_GO] && s_d.on) begin
               s_d.go = 1'b1;
               s_d.st = sacc_pkg::SACC_ARMED;
            end else if (s_q.on && s_q.auto && s_q.trigSel != `SACC_TRIG_FREE
                         && trigRise) begin
               s_d.go = 1'b1;
               s_d.presClr = 1'b1;
               s_d.st = sacc_pkg::SACC_ARMED;
            end
         end
         sacc_pkg::SACC_ARMED: begin
            if (tick) begin
               s_d.st = sacc_pkg::SACC_CONVERT;
               s_d.cnt = 5'd0;
               s_d.dac = 10'h000;
            end
         end
         sacc_pkg::SACC_CONVERT: begin
            // Edges seen here are dropped, not remembered
            if (tick) begin
               s_d.cnt = s_q.cnt + 5'd1;
               if (s_q.cnt == convLen - `SACC_RES_BITS - 5'd1) begin
                  s_d.dac = `SACC_SAR_MSB;
               end else if (inBits) begin
                  s_d.dac = nextDac;
               end
            end
            if (complete) begin
               if (!s_d.lock) begin
                  s_d.result = nextDac;
               end
               s_d.flag = 1'b1;
               s_d.warm = 1'b1;
               s_d.cnt = 5'd0;
               if (freeRun) begin
                  s_d.st = sacc_pkg::SACC_ARMED;
               end else begin
                  s_d.go = 1'b0;
                  s_d.st = sacc_pkg::SACC_IDLE;
               end
            end
         end
         default: begin
            s_d.st = sacc_pkg::SACC_IDLE;
         end
      endcase
      // Switching off aborts and rearms the long first conversion
      if (!s_d.on) begin
         s_d.st = sacc_pkg::SACC_IDLE;
         s_d.go = 1'b0;
         s_d.warm = 1'b0;
         s_d.cnt = 5'd0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign prdata = {24'h000000, s_q.rdByte};
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign feEnable = s_q.feEn;
   assign feChannel = s_q.feChan;
   assign feReference = s_q.feRef;
   assign feDacCode = s_q.dac;
   assign convDoneFlag = s_q.flag;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_go_busy;
      s_q.st == sacc_pkg::SACC_CONVERT |-> s_q.go;
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("go low during conversion");

   property p_lock_keeps;
      (ce && complete && s_q.lock && !(setup && !pwrite && paddr == `SACC_OFF_RES_HI))
         |=> $stable(s_q.result);
   endproperty
   a_lock_keeps: assert property (p_lock_keeps) else $error("blocked result changed");

   property p_flag_done;
      (ce && complete) |=> s_q.flag;
   endproperty
   a_flag_done: assert property (p_flag_done) else $error("done flag not set");

   property p_go_clear;
      (ce && complete && !freeRun && s_d.on) |=> !s_q.go && s_q.st == sacc_pkg::SACC_IDLE;
   endproperty
   a_go_clear: assert property (p_go_clear) else $error("go not cleared at end");

   property p_chan_hold;
      (s_q.st == sacc_pkg::SACC_CONVERT) ##1 (s_q.st == sacc_pkg::SACC_CONVERT)
         |-> $stable(s_q.feChan) && $stable(s_q.feRef);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("selection moved mid conversion");

   property p_off_idle;
      (ce && !s_d.on) |=> s_q.st == sacc_pkg::SACC_IDLE && !s_q.go && !s_q.warm;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("converter off but active");

   property p_edge_ignored;
      (ce && s_q.st == sacc_pkg::SACC_CONVERT && !complete && s_d.on && trigRise)
         |=> s_q.st == sacc_pkg::SACC_CONVERT && !s_q.presClr;
   endproperty
   a_edge_ignored: assert property (p_edge_ignored) else $error("edge disturbed conversion");

   property p_trig_start;
      (ce && s_q.st == sacc_pkg::SACC_IDLE && s_q.on && s_d.on && s_q.auto && !wrEn
       && s_q.trigSel != `SACC_TRIG_FREE && trigRise)
         |=> s_q.go && s_q.presClr && !tick;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

   property p_free_run;
      (ce && complete && freeRun && s_d.on) |=> s_q.go && s_q.st == sacc_pkg::SACC_ARMED;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run stopped");

   property p_release;
      (ce && setup && !pwrite && paddr == `SACC_OFF_RES_HI) |=> !s_q.lock;
   endproperty
   a_release: assert property (p_release) else $error("lock not released");

   property p_fe_follow;
      (ce && s_d.on && s_q.st != sacc_pkg::SACC_CONVERT) |=> s_q.feChan == s_q.chanSel;
   endproperty
   a_fe_follow: assert property (p_fe_follow) else $error("selection not applied");

   property p_lock_set;
      (ce && setup && !pwrite && paddr == `SACC_OFF_RES_LO) |=> s_q.lock;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock not taken");

   property p_off_sel;
      (ce && !s_d.on) |=> $stable(s_q.feChan) && $stable(s_q.feRef);
   endproperty
   a_off_sel: assert property (p_off_sel) else $error("selection moved while off");

   property p_result_upd;
      (ce && complete && !s_d.lock) |=> s_q.result == $past(nextDac);
   endproperty
   a_result_upd: assert property (p_result_upd) else $error("result not written");
endmodule

// >>> verification/sacc_fe_model.sv
// Comparator front-end model holding one analog level that the bench sets and may change
`timescale 1ns/1ps
module sacc_fe_model (
   input wire logic enable,
   input wire logic [9:0] level,
   input wire logic [9:0] dacCode,
   output logic compare
);
   // Level sits half a step above its code, so a trial never ties
   assign compare = enable & (dacCode <= level);
endmodule

// >>> verification/sacc_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sacc_cfg.svh"
module sacc_tb_top;
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, err;
   logic feCompare, feEnable, convDoneFlag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] trigEvents;
   logic [4:0] feChannel;
   logic [1:0] feReference;
   logic [9:0] feDacCode, level;
   int errors, num_checks, cycles;

   sacc_top #(.PRESCALE(8'd2)) i_sacc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigEvents(trigEvents), .feCompare(feCompare),
      .feEnable(feEnable), .feChannel(feChannel), .feReference(feReference),
      .feDacCode(feDacCode), .convDoneFlag(convDoneFlag));

   sacc_fe_model i_sacc_fe_model (.enable(feEnable), .level(level), .dacCode(feDacCode),
      .compare(feCompare));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) chk("pready", 1, 0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      do begin
         apb(1'b0, `SACC_OFF_CTRL_A, 32'h0);
         n++;
      end while (rd[6] !== 1'b0 && n < 100);
   endtask

   // Start with flag cleared, then time until the done flag rises
   task automatic conv(input int len);
      int t0;
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hd0);
      @(posedge clk);
      t0 = cycles;
      while (convDoneFlag !== 1'b1 && cycles < t0 + 400) @(posedge clk);
      chk("length", 1, (cycles - t0 >= 2 * len - 1) && (cycles - t0 <= 2 * len + 4));
      rdc(`SACC_OFF_CTRL_A, 32'h90, "go cleared with flag");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdc(`SACC_OFF_CTRL_A, 32'h0, "ctrl a reset");
      rdc(`SACC_OFF_CTRL_B, 32'h0, "ctrl b reset");
      rdc(`SACC_OFF_INSEL, 32'h0, "insel reset");
      rdc(12'h020, 32'h0, "unmapped data");
      chk("unmapped error", 1, err);
   endtask

   task automatic t_single;
      apb(1'b1, `SACC_OFF_INSEL, 32'h85);
      @(posedge clk);
      chk("channel while off", 0, feChannel);
      chk("reference while off", 0, feReference);
      apb(1'b1, `SACC_OFF_CTRL_A, 32'h80);
      @(posedge clk);
      chk("channel on", 5, feChannel);
      chk("reference on", 2, feReference);
      conv(25);
      rdc(`SACC_OFF_RES_LO, {24'h0, level[7:0]}, "right low");
      rdc(`SACC_OFF_RES_HI, {30'h0, level[9:8]}, "right high");
      conv(13);
   endtask

   task automatic t_align_lock;
      apb(1'b1, `SACC_OFF_INSEL, 32'h25);
      conv(13);
      rdc(`SACC_OFF_RES_LO, {24'h0, level[1:0], 6'h0}, "left low");
      level <= 10'h136;
      conv(13);
      rdc(`SACC_OFF_RES_HI, 32'hb2, "locked high");
      conv(13);
      rdc(`SACC_OFF_RES_LO, 32'h80, "released low");
      rdc(`SACC_OFF_RES_HI, 32'h4d, "released high");
   endtask

   task automatic t_channel;
      apb(1'b1, `SACC_OFF_INSEL, 32'h03);
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hd0);
      repeat (8) @(posedge clk);
      apb(1'b1, `SACC_OFF_INSEL, 32'h07);
      @(posedge clk);
      chk("old channel held", 3, feChannel);
      wait_done;
      repeat (2) @(posedge clk);
      chk("new channel", 7, feChannel);
   endtask

   task automatic t_trigger;
      apb(1'b1, `SACC_OFF_CTRL_B, 32'h1);
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hb0);
      trigEvents <= 8'h04;
      repeat (6) @(posedge clk);
      rdc(`SACC_OFF_CTRL_A, 32'ha0, "other source idle");
      trigEvents <= 8'h06;
      repeat (4) @(posedge clk);
      rdc(`SACC_OFF_CTRL_A, 32'he0, "trigger started");
      trigEvents <= 8'h04;
      @(posedge clk);
      trigEvents <= 8'h06;
      wait_done;
      chk("trigger done", 32'hb0, rd);
      repeat (6) @(posedge clk);
      rdc(`SACC_OFF_CTRL_A, 32'hb0, "no restart");
      trigEvents <= 8'h00;
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hf0);
      wait_done;
      chk("go with auto on", 32'hb0, rd);
   endtask

   task automatic t_freerun;
      int n;
      apb(1'b1, `SACC_OFF_CTRL_B, 32'h0);
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hf0);
      @(posedge clk);
      n = 0;
      while (convDoneFlag !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
      rdc(`SACC_OFF_CTRL_A, 32'hf0, "free run busy");
      apb(1'b1, `SACC_OFF_CTRL_A, 32'hb0);
      repeat (40) @(posedge clk);
      chk("flag again", 1, convDoneFlag);
      repeat (60) @(posedge clk);
      rdc(`SACC_OFF_CTRL_A, 32'hf0, "still running");
      apb(1'b1, `SACC_OFF_CTRL_A, 32'h0);
      @(posedge clk);
      chk("converter off", 0, feEnable);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      trigEvents = 8'h00;
      level = 10'h2c9;
      errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_single;
      t_align_lock;
      t_channel;
      t_trigger;
      t_freerun;
      end_sim;
   end
endmodule
